// >>> hw/tdsc_pkg.sv
// Shared constants for the transceiver detect and switch control block
package tdsc_pkg;
  localparam int unsigned CLK_HZ            = 20000000;
  // ID ground pulse width and pre-pulse delay, in microseconds
  localparam int unsigned ID_PULSE_US       = 100;
  localparam int unsigned ID_DELAY_US       = 1000;
  localparam int unsigned ID_PULSE_CYC      = (CLK_HZ / 1000000) * ID_PULSE_US;
  localparam int unsigned ID_DELAY_CYC      = (CLK_HZ / 1000000) * ID_DELAY_US;
  localparam int unsigned CNT_W             = 24;
  localparam int unsigned DATA_W            = 8;
  localparam int unsigned SPI_WORD_BITS     = 25;
  localparam logic        PULLUP_EN_RST     = 1'b1;
  localparam logic        SEL_SPI           = 1'b0;
  typedef enum logic [1:0] {TDSC_IDLE, TDSC_WAIT, TDSC_PULSE} tdsc_id_st_t;
endpackage : tdsc_pkg

// >>> hw/tdsc_sync.sv
// Two-flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module tdsc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // tdsc_sync
`default_nettype wire

// >>> hw/tdsc_top.sv
// Detect, ID ground pulse and resistor switch control of the transceiver
// Notes on behaviour
// - I2C mode moves eight data bits per register address.
// - SPI mode moves 25 bits per address; only low eight count.
// - Bus select pin sampled at reset: low picks SPI, high I2C.
// - Register port is always a slave, never starts transfers.
// - Bus-valid flag follows the session-valid comparator.
// - With both supplies, report ID open or grounded; resistor gives neither.
// - ID ground force holds switch on; all bits clear keeps it off.
// - Pulse-now pulses once; pulse-delayed waits then pulses; both self-clear.
// - ID pull-up to reference switch opens while ID exceeds reference.
// - D+ pull-up enable, default on, works only with valid session.
// - Session request force connects D+ pull-up whenever reset is high.
// - Otherwise pull-up needs enable, valid session, I/O supply, reset high.
// - Idle boost switch closed while bus idle, open while active.
// - Weak pull-up needs its enable and a valid session.
// - D+ pull-down closed exactly while its enable is set.
// - D- pull-down closed exactly while its enable is set.
// - Carkit flag clears when D+ sits below carkit threshold.
// - Carkit detector active only with analog audio enabled.
// - Names with an _N suffix are active low.
`timescale 1ns/1ps
`default_nettype none
module tdsc_top #(
  parameter int unsigned PULSE_CYC = tdsc_pkg::ID_PULSE_CYC,
  parameter int unsigned DELAY_CYC = tdsc_pkg::ID_DELAY_CYC
) (
  input  wire logic CLK_SYS,
  input  wire logic RESET_N,
  // Strap and analog comparator inputs, all asynchronous
  input  wire logic BUS_SELECT_PIN,
  input  wire logic VBUS_ABOVE_SVC,
  input  wire logic VCC_PRESENT,
  input  wire logic VCC_IO_PRESENT,
  input  wire logic ID_OPEN_CMP,
  input  wire logic ID_GROUND_CMP,
  input  wire logic ID_ABOVE_VREF,
  input  wire logic DPLUS_BELOW_CARKIT,
  input  wire logic BUS_ACTIVE,
  // Control bits from the register file
  input  wire logic ID_GROUND_FORCE,
  input  wire logic ID_PULSE_NOW_SET,
  input  wire logic ID_PULSE_DELAYED_SET,
  input  wire logic DPLUS_PULLUP_ENABLE_WR,
  input  wire logic DPLUS_PULLUP_ENABLE_VAL,
  input  wire logic SESSION_REQUEST_PULLUP_FORCE,
  input  wire logic DPLUS_WEAK_PULLUP_ENABLE,
  input  wire logic DPLUS_PULLDOWN_ENABLE,
  input  wire logic DMINUS_PULLDOWN_ENABLE,
  input  wire logic ANALOG_AUDIO_ENABLE,
  input  wire logic CARKIT_FLAG_SET,
  // Status and switch outputs
  output var  logic SPI_MODE,
  output var  logic I2C_MODE,
  output var  logic [4:0] WORD_BITS,
  output var  logic SLAVE_ONLY,
  output var  logic VBUS_VALID_FLAG,
  output var  logic ID_OPEN_FLAG,
  output var  logic ID_GROUNDED_FLAG,
  output var  logic ID_PULSE_NOW,
  output var  logic ID_PULSE_DELAYED,
  output var  logic DPLUS_PULLUP_ENABLE,
  output var  logic ID_GROUND_SWITCH,
  output var  logic ID_VREF_SWITCH,
  output var  logic MAIN_PULLUP_SWITCH,
  output var  logic IDLE_BOOST_SWITCH,
  output var  logic WEAK_PULLUP_SWITCH,
  output var  logic DPLUS_PULLDOWN_SWITCH,
  output var  logic DMINUS_PULLDOWN_SWITCH,
  output var  logic CARKIT_DETECT_ON,
  output var  logic CARKIT_INTERRUPT_FLAG
);
  localparam int unsigned NS = 9;
  // Synchroniser stages the strap must wait out after reset release
  localparam int unsigned STRAP_WAIT = 2;

  logic [NS-1:0]        raw_s;
  logic [NS-1:0]        syn_s;
  logic                 sel_s;
  logic                 vbus_s;
  logic                 vcc_s;
  logic                 vio_s;
  logic                 idopen_s;
  logic                 idgnd_s;
  logic                 idvref_s;
  logic                 dpl_s;
  logic                 busact_s;
  logic                 strap_pend_q;
  logic [1:0]           strap_wait_q;
  logic                 mode_i2c_q;
  tdsc_pkg::tdsc_id_st_t id_st_q;
  logic [tdsc_pkg::CNT_W-1:0] cnt_q;
  logic                 pulse_now_q;
  logic                 pulse_dly_q;
  logic                 pu_en_q;
  logic                 carkit_q;
  logic                 norm_pwr;

  assign raw_s = {BUS_SELECT_PIN, VBUS_ABOVE_SVC, VCC_PRESENT, VCC_IO_PRESENT,
                  ID_OPEN_CMP, ID_GROUND_CMP, ID_ABOVE_VREF, DPLUS_BELOW_CARKIT,
                  BUS_ACTIVE};

  // All pin and comparator levels cross into the clock domain first;
  // one shared synchroniser keeps every level equally delayed
  tdsc_sync #(.W(NS)) u_sync (
    .clk   (CLK_SYS),
    .rst_n (RESET_N),
    .d     (raw_s),
    .q     (syn_s)
  );

  assign {sel_s, vbus_s, vcc_s, vio_s, idopen_s, idgnd_s, idvref_s, dpl_s, busact_s} = syn_s;

  // Strap caught once the synchroniser carries the pin level; its stages
  // reset to zero, so an earlier capture would always pick SPI
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_wait_q <= 2'(STRAP_WAIT);
      strap_pend_q <= 1'b1;
      mode_i2c_q   <= 1'b0;
    end else if (strap_wait_q != 2'h0) begin
      strap_wait_q <= strap_wait_q - 1'b1;
    end else if (strap_pend_q) begin
      strap_pend_q <= 1'b0;
      mode_i2c_q   <= (sel_s != tdsc_pkg::SEL_SPI);
    end
  end

  // Serial port mode and word size shown to the serial front end
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      SPI_MODE   <= 1'b0;
      I2C_MODE   <= 1'b0;
      WORD_BITS  <= 5'h00;
      SLAVE_ONLY <= 1'b1;
    end else begin
      SPI_MODE   <= !strap_pend_q && !mode_i2c_q;
      I2C_MODE   <= !strap_pend_q && mode_i2c_q;
      // Same register set either way; SPI upper bits are don't care
      // Word size shows SPI until the strap has been taken
      WORD_BITS  <= mode_i2c_q ? 5'(tdsc_pkg::DATA_W)
                               : 5'(tdsc_pkg::SPI_WORD_BITS);
      SLAVE_ONLY <= 1'b1;
    end
  end

  assign norm_pwr = vcc_s && vio_s;

  // Bus-valid flag follows the synchronised session-valid comparator
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      VBUS_VALID_FLAG <= 1'b0;
    end else begin
      VBUS_VALID_FLAG <= vbus_s;
    end
  end

  // ID flags only meaningful with both supplies; grounded wins if both
  // comparators claim it, so the two flags are never high together
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ID_OPEN_FLAG     <= 1'b0;
      ID_GROUNDED_FLAG <= 1'b0;
    end else begin
      ID_OPEN_FLAG     <= norm_pwr && idopen_s && !idgnd_s;
      ID_GROUNDED_FLAG <= norm_pwr && idgnd_s;
    end
  end

  // ID ground pulse sequencer; a set arriving mid-pulse is ignored
  // One down-counter serves both the pre-pulse delay and the pulse width
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      id_st_q     <= tdsc_pkg::TDSC_IDLE;
      cnt_q       <= '0;
      pulse_now_q <= 1'b0;
      pulse_dly_q <= 1'b0;
    end else begin
      unique case (id_st_q)
        tdsc_pkg::TDSC_IDLE: begin
          // Both set bits at once is undefined; neither is taken
          if (ID_PULSE_NOW_SET && !ID_PULSE_DELAYED_SET) begin
            pulse_now_q <= 1'b1;
            cnt_q       <= tdsc_pkg::CNT_W'(PULSE_CYC - 1);
            id_st_q     <= tdsc_pkg::TDSC_PULSE;
          end else if (ID_PULSE_DELAYED_SET && !ID_PULSE_NOW_SET) begin
            pulse_dly_q <= 1'b1;
            cnt_q       <= tdsc_pkg::CNT_W'(DELAY_CYC - 1);
            id_st_q     <= tdsc_pkg::TDSC_WAIT;
          end
        end
        tdsc_pkg::TDSC_WAIT: begin
          if (cnt_q == '0) begin
            cnt_q   <= tdsc_pkg::CNT_W'(PULSE_CYC - 1);
            id_st_q <= tdsc_pkg::TDSC_PULSE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        tdsc_pkg::TDSC_PULSE: begin
          if (cnt_q == '0) begin
            pulse_now_q <= 1'b0;
            pulse_dly_q <= 1'b0;
            id_st_q     <= tdsc_pkg::TDSC_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: id_st_q <= tdsc_pkg::TDSC_IDLE;
      endcase
    end
  end

  // Ground switch: force overrides the sequencer, which cannot cancel it
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ID_GROUND_SWITCH <= 1'b0;
    end else begin
      ID_GROUND_SWITCH <= ID_GROUND_FORCE || (id_st_q == tdsc_pkg::TDSC_PULSE);
    end
  end

  // Pull-up to reference switch opens while ID sits above the reference
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ID_VREF_SWITCH <= 1'b0;
    end else begin
      ID_VREF_SWITCH <= !idvref_s;
    end
  end

  // D+ pull-up enable bit, enabled by default
  // Write strobe and value arrive together from the register file
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      pu_en_q <= tdsc_pkg::PULLUP_EN_RST;
    end else if (DPLUS_PULLUP_ENABLE_WR) begin
      pu_en_q <= DPLUS_PULLUP_ENABLE_VAL;
    end
  end

  // Main D+ pull-up; session request force skips the supply checks so that
  // pulsing works with the bus supply down, and reset low keeps it off
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      MAIN_PULLUP_SWITCH <= 1'b0;
    end else begin
      MAIN_PULLUP_SWITCH <= SESSION_REQUEST_PULLUP_FORCE
                            || (pu_en_q && vbus_s && vio_s);
    end
  end

  // Idle boost lowers the pull-up resistance only while the bus is quiet
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      IDLE_BOOST_SWITCH <= 1'b0;
    end else begin
      IDLE_BOOST_SWITCH <= !busact_s;
    end
  end

  // Weak pull-up, gated by the session-valid comparator
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      WEAK_PULLUP_SWITCH <= 1'b0;
    end else begin
      WEAK_PULLUP_SWITCH <= DPLUS_WEAK_PULLUP_ENABLE && vbus_s;
    end
  end

  // Pull-downs follow their enables with no supply gating
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      DPLUS_PULLDOWN_SWITCH  <= 1'b0;
      DMINUS_PULLDOWN_SWITCH <= 1'b0;
    end else begin
      DPLUS_PULLDOWN_SWITCH  <= DPLUS_PULLDOWN_ENABLE;
      DMINUS_PULLDOWN_SWITCH <= DMINUS_PULLDOWN_ENABLE;
    end
  end

  // Carkit flag: set wins over a same-cycle comparator clear
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      carkit_q         <= 1'b0;
      CARKIT_DETECT_ON <= 1'b0;
    end else begin
      CARKIT_DETECT_ON <= ANALOG_AUDIO_ENABLE;
      if (!ANALOG_AUDIO_ENABLE) begin
        carkit_q <= 1'b0;
      end else if (CARKIT_FLAG_SET) begin
        carkit_q <= 1'b1;
      end else if (dpl_s) begin
        carkit_q <= 1'b0;
      end
    end
  end

  // Read-back of control and flag state; _N ports treated active low
  assign ID_PULSE_NOW          = pulse_now_q;
  assign ID_PULSE_DELAYED      = pulse_dly_q;
  assign DPLUS_PULLUP_ENABLE   = pu_en_q;
  assign CARKIT_INTERRUPT_FLAG = carkit_q;
endmodule // tdsc_top
`default_nettype wire

// >>> tb/tdsc_props.sv
// Concurrent checks on the switch, flag and pulse ports of tdsc_top
`timescale 1ns/1ps
`default_nettype none
module tdsc_props #(parameter int unsigned PULSE_CYC = 4, parameter int unsigned DELAY_CYC = 8) (
  input wire logic       CLK_SYS,
  input wire logic       RESET_N,
  input wire logic       VBUS_ABOVE_SVC,
  input wire logic       ID_GROUND_FORCE,
  input wire logic       DPLUS_PULLDOWN_ENABLE,
  input wire logic       SESSION_REQUEST_PULLUP_FORCE,
  input wire logic       ANALOG_AUDIO_ENABLE,
  input wire logic       SPI_MODE,
  input wire logic [4:0] WORD_BITS,
  input wire logic       SLAVE_ONLY,
  input wire logic       VBUS_VALID_FLAG,
  input wire logic       ID_PULSE_NOW,
  input wire logic       ID_PULSE_DELAYED,
  input wire logic       ID_GROUND_SWITCH,
  input wire logic       MAIN_PULLUP_SWITCH,
  input wire logic       DPLUS_PULLDOWN_SWITCH,
  input wire logic       CARKIT_INTERRUPT_FLAG
);
  localparam int PW  = PULSE_CYC;
  localparam int PW1 = PULSE_CYC - 1;
  localparam int DW1 = DELAY_CYC + 1;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // Switch follows the bit one cycle late, so the bit falls first
  sequence s_now;
    ##1 ID_GROUND_SWITCH ##PW1 $fell(ID_PULSE_NOW) ##1 $fell(ID_GROUND_SWITCH);
  endsequence
  sequence s_late;
    !ID_GROUND_SWITCH ##DW1 $rose(ID_GROUND_SWITCH) ##PW $fell(ID_GROUND_SWITCH);
  endsequence
  AST_NOW_PULSE: assert property ($rose(ID_PULSE_NOW) && !ID_GROUND_FORCE |-> s_now)
    else $error("pulse now timing wrong");
  AST_LATE_PULSE: assert property ($rose(ID_PULSE_DELAYED) && !ID_GROUND_FORCE |-> s_late)
    else $error("delayed pulse timing wrong");
  AST_FORCE_ON: assert property ($past(RESET_N) && $past(ID_GROUND_FORCE) |-> ID_GROUND_SWITCH)
    else $error("ground force ignored");
  AST_ALL_OFF: assert property ($past(RESET_N) && !$past(ID_GROUND_FORCE) &&
    !$past(ID_PULSE_NOW) && !$past(ID_PULSE_DELAYED) |-> !ID_GROUND_SWITCH)
    else $error("ground switch on while idle");
  AST_DPLUS_PULLDOWN_ENABLE: assert property ($past(RESET_N) |->
    DPLUS_PULLDOWN_SWITCH == $past(DPLUS_PULLDOWN_ENABLE)) else $error("pull-down mismatch");
  AST_SRP: assert property ($past(RESET_N) && $past(SESSION_REQUEST_PULLUP_FORCE) |->
    MAIN_PULLUP_SWITCH) else $error("session request pull-up off");
  AST_CARKIT_OFF: assert property ($past(RESET_N) && !$past(ANALOG_AUDIO_ENABLE) |->
    !CARKIT_INTERRUPT_FLAG) else $error("carkit flag without audio");
  AST_VBUS: assert property ($past(RESET_N, 4) |->
    VBUS_VALID_FLAG == $past(VBUS_ABOVE_SVC, 3)) else $error("bus valid flag lag wrong");
  AST_MODE: assert property ($past(RESET_N, 4) |-> SLAVE_ONLY &&
    WORD_BITS == (SPI_MODE ? 5'h19 : 5'h08)) else $error("word size or slave wrong");
endmodule // tdsc_props
bind tdsc_top tdsc_props #(.PULSE_CYC(PULSE_CYC), .DELAY_CYC(DELAY_CYC)) u_props (.*);
`default_nettype wire

// >>> tb/tdsc_host_model.sv
// Host model: drives control bits as its register writes would
`timescale 1ns/1ps
`default_nettype none
module tdsc_host_model (
  input  wire logic        clk,
  output var  logic [10:0] ctl
);
  // Set and write strobes live one cycle only, as register writes do
  localparam logic [10:0] STROBES = 11'h40E;
  initial ctl = 11'h000;
  task automatic wr(input logic [10:0] v);
    @(negedge clk);
    ctl = v;
    @(negedge clk);
    ctl = v & ~STROBES;
  endtask
endmodule // tdsc_host_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for tdsc_top with a host model on the control bits
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int P = 4;
  localparam int D = 8;
  logic clk = 1'b0, rst_n = 1'b0, sel = 1'b0, pu_e = 1'b1, ck_e = 1'b0;
  logic [7:0]  an = 8'h00, a;
  logic [10:0] c, ctl;
  logic [11:0] e;
  logic [31:0] exp_q[$], got_q[$];
  wire logic [17:0] obs;
  wire logic [4:0]  wb;
  int n, num_errors = 0, num_checks = 0;
  initial forever #25 clk = ~clk;
  tdsc_host_model host (.clk(clk), .ctl(ctl));
  tdsc_top #(.PULSE_CYC(P), .DELAY_CYC(D)) dut (
    .CLK_SYS(clk), .RESET_N(rst_n), .BUS_SELECT_PIN(sel),
    .VBUS_ABOVE_SVC(an[0]), .VCC_PRESENT(an[1]), .VCC_IO_PRESENT(an[2]),
    .ID_OPEN_CMP(an[3]), .ID_GROUND_CMP(an[4]), .ID_ABOVE_VREF(an[5]),
    .DPLUS_BELOW_CARKIT(an[6]), .BUS_ACTIVE(an[7]),
    .ID_GROUND_FORCE(ctl[0]), .ID_PULSE_NOW_SET(ctl[1]), .ID_PULSE_DELAYED_SET(ctl[2]),
    .DPLUS_PULLUP_ENABLE_WR(ctl[3]), .DPLUS_PULLUP_ENABLE_VAL(ctl[4]),
    .SESSION_REQUEST_PULLUP_FORCE(ctl[5]), .DPLUS_WEAK_PULLUP_ENABLE(ctl[6]),
    .DPLUS_PULLDOWN_ENABLE(ctl[7]), .DMINUS_PULLDOWN_ENABLE(ctl[8]),
    .ANALOG_AUDIO_ENABLE(ctl[9]), .CARKIT_FLAG_SET(ctl[10]),
    .SPI_MODE(obs[12]), .I2C_MODE(obs[13]), .WORD_BITS(wb), .SLAVE_ONLY(obs[14]),
    .VBUS_VALID_FLAG(obs[0]), .ID_OPEN_FLAG(obs[1]), .ID_GROUNDED_FLAG(obs[2]),
    .ID_PULSE_NOW(obs[16]), .ID_PULSE_DELAYED(obs[17]), .DPLUS_PULLUP_ENABLE(obs[15]),
    .ID_GROUND_SWITCH(obs[3]), .ID_VREF_SWITCH(obs[4]), .MAIN_PULLUP_SWITCH(obs[5]),
    .IDLE_BOOST_SWITCH(obs[6]), .WEAK_PULLUP_SWITCH(obs[7]),
    .DPLUS_PULLDOWN_SWITCH(obs[8]), .DMINUS_PULLDOWN_SWITCH(obs[9]),
    .CARKIT_DETECT_ON(obs[10]), .CARKIT_INTERRUPT_FLAG(obs[11]));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    exp_q.push_back(x);
    got_q.push_back(g);
  endtask
  // Oldest note is matched against each posted result
  initial forever begin
    wait (got_q.size() > 0);
    num_checks++;
    if (got_q[0] !== exp_q[0]) begin
      num_errors++;
      $display("Error %0t: got %0h expected %0h", $time, got_q[0], exp_q[0]);
    end
    void'(got_q.pop_front());
    void'(exp_q.pop_front());
  end
  // Cycles to switch rise, then switch width; bounded so a stuck switch cannot hang
  task automatic measure(input int lead, input int wid);
    for (n = 0; obs[3] !== 1'b1 && n < 99; n++) @(negedge clk);
    chk(n, lead);
    for (n = 0; obs[3] === 1'b1 && n < 99; n++) @(negedge clk);
    chk(n, wid);
    chk(obs[17:16], 2'b00);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    num_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h9BF15F88));
    sel = 1'($urandom());
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk({obs[13:12], wb}, {sel, !sel, sel ? 5'h08 : 5'h19});
    chk(obs[15:14], 2'b11);
    // Comparators settle first, so the carkit set never races a stale clear
    for (int k = 0; k < 40; k++) begin
      a = 8'($urandom());
      c = 11'($urandom()) & 11'h7F9;
      @(negedge clk) an = a;
      repeat (4) @(negedge clk);
      host.wr(c);
      repeat (3) @(negedge clk);
      if (c[3]) pu_e = c[4];
      ck_e = c[9] & !a[6] & (c[10] | ck_e);
      e = {ck_e, c[9:7], c[6] & a[0], !a[7], c[5] | (pu_e & a[0] & a[2]), !a[5], c[0],
           a[1] & a[2] & a[4], a[1] & a[2] & a[3] & !a[4], a[0]};
      chk(obs[11:0], e);
      chk(obs[15], pu_e);
    end
    // Mid-run reset with the strap flipped; the pull-up enable returns to on
    @(negedge clk) rst_n = 1'b0;
    sel = !sel;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk({obs[13:12], wb}, {sel, !sel, sel ? 5'h08 : 5'h19});
    chk(obs[15:14], 2'b11);
    host.wr(11'h000);
    host.wr(11'h002);
    measure(1, P);
    host.wr(11'h004);
    measure(D + 1, P);
    // Second set lands mid-pulse and must neither extend nor repeat it
    host.wr(11'h002);
    host.wr(11'h002);
    measure(0, P - 1);
    host.wr(11'h006);
    for (n = 0; n < D + P + 4 && obs[3] !== 1'b1; n++) @(negedge clk);
    chk(n, D + P + 4);
    chk(obs[17:16], 2'b00);
    repeat (2) @(negedge clk);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
